// ### spd_pkg.sv
// Shared constants for the serial nonvolatile SRAM link: opcodes, status layout, timing, controller registers
package spd_pkg;
  localparam int CLK_NS = 40;
  localparam int RESTORE_TIME_NS = 20000;
  localparam int RESTORE_CYC = (RESTORE_TIME_NS + CLK_NS - 1) / CLK_NS;
  localparam int WDELAY_TIME_NS = 25000;
  localparam int WDELAY_CYC = (WDELAY_TIME_NS + CLK_NS - 1) / CLK_NS;
  localparam int SCK_MAX_MHZ = 40;
  localparam int HALF_CYC = 4;
  localparam int ADDR_BITS = 17;
  localparam int ADDR_BYTES = 3;

  localparam logic [7:0] READ_CMD = 8'h03;
  localparam logic [7:0] WRITE_CMD = 8'h02;
  localparam logic [7:0] SET_WRITE_LATCH_CMD = 8'h06;
  localparam logic [7:0] CLEAR_WRITE_LATCH_CMD = 8'h04;
  localparam logic [7:0] STATUS_READ_CMD = 8'h05;
  localparam logic [7:0] STATUS_WRITE_CMD = 8'h01;
  localparam logic [7:0] SAVE_CMD = 8'h3C;
  localparam logic [7:0] RESTORE_CMD = 8'h60;
  localparam logic [7:0] AUTO_SAVE_ON_CMD = 8'h59;
  localparam logic [7:0] AUTO_SAVE_OFF_CMD = 8'h19;

  localparam int BUSY_BIT = 0;
  localparam int WRITE_LATCH_BIT = 1;
  localparam int BLOCK_PROTECT_LOW_BIT = 2;
  localparam int BLOCK_PROTECT_HIGH_BIT = 3;
  localparam int PIN_PROTECT_ENABLE_BIT = 7;

  localparam logic [1:0] REG_CTRL = 2'h0;
  localparam logic [1:0] REG_DATA = 2'h1;
  localparam logic [1:0] REG_STAT = 2'h2;
  localparam int CTRL_MODE3_BIT = 0;
  localparam int DATA_LAST_BIT = 8;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_SEL_BIT = 1;
endpackage

// ### spd_link_if.sv
// Four-wire serial link between the controller and the memory front end
`timescale 1ns/1ns
interface spd_link_if;
  logic cs_n;
  logic sck;
  logic si;
  logic so_out;
  logic so_oe_n;
  wire so;

  // Released output reads as a pulled-up line
  assign so = so_oe_n ? 1'b1 : so_out;

  modport dev_mp (
    input cs_n,
    input sck,
    input si,
    output so_out,
    output so_oe_n
  );

  modport host_mp (
    output cs_n,
    output sck,
    output si,
    input so
  );
endinterface

// ### spd_device_end.sv
// Serial slave front end of the nonvolatile SRAM: framing, decode, status, power handling
`timescale 1ns/1ns
// Contract
// - Sample input on rising clock edges
// - Change output data on falling clock edges
// - Clock level at select fall picks mode
// - Mode 3 ignores initial high clock level
// - Master idles clock at mode's level
// - First byte is opcode, then address/data
// - Master sends one opcode per select
// - All bytes shift most significant first
// - Three address bytes, low 17 bits used
// - Master sends zeros in unused bits; the bench write sends ones there
// - Bad opcode: ignore rest, output tristated
// - Needs a select falling edge after powerup
// - Ignore until supply good, then restore
// - After reset: deselected, latch and 4-6 zero
// - Supply loss: stop, delay, conditional save
// - Standby once deselected and not busy
// - Master clock no faster than 40 MHz
// - Decode memory read and write opcodes
// - Decode latch and status opcodes
// - Decode save, restore, autosave opcodes
// - Status byte bit layout
module spd_device_end #(
  parameter int RESTORE_CYC = spd_pkg::RESTORE_CYC,
  parameter int WDELAY_CYC = spd_pkg::WDELAY_CYC
) (
  input wire logic sys_clk,
  input wire logic reset,
  spd_link_if.dev_mp link,
  input wire logic power_good,
  input wire logic nv_busy,
  input wire logic [7:0] mem_rdata,
  output logic [spd_pkg::ADDR_BITS-1:0] mem_addr,
  output logic [7:0] mem_wdata,
  output logic mem_wr,
  output logic mem_rd,
  output logic nv_save_req,
  output logic nv_restore_req,
  output logic active,
  output logic standby,
  output logic spi_mode3
);
  typedef enum logic [4:0] {
    DS_IDLE = 5'b00001,
    DS_OPC = 5'b00010,
    DS_ADDR = 5'b00100,
    DS_DATA = 5'b01000,
    DS_IGNORE = 5'b10000
  } spd_dstate_type;

  localparam int AW = spd_pkg::ADDR_BITS;

  initial begin
    if (RESTORE_CYC < 1 || RESTORE_CYC > 65535 || WDELAY_CYC < 1 || WDELAY_CYC > 65535) begin
      $error("spd_device_end: delay counts out of range");
    end
  end

  function automatic logic [AW-1:0] addr_inc(input logic [AW-1:0] a);
    addr_inc = a + {{(AW-1){1'b0}}, 1'b1};
  endfunction

  spd_dstate_type state_ff;
  logic [3:0] sync1_ff;
  logic [3:0] sync2_ff;
  logic sck_d_ff;
  logic cs_d_ff;
  logic pg_d_ff;
  logic [2:0] bit_cnt_ff;
  logic [1:0] addr_byte_ff;
  logic [7:0] rx_sh_ff;
  logic [7:0] tx_sh_ff;
  logic [7:0] op_ff;
  logic [AW-1:0] addr_ff;
  logic [AW-1:0] mem_addr_ff;
  logic [7:0] mem_wdata_ff;
  logic mem_wr_ff;
  logic mem_rd_ff;
  logic so_ff;
  logic so_oe_n_ff;
  logic mode3_ff;
  logic wel_ff;
  logic [1:0] bp_ff;
  logic ppe_ff;
  logic autosave_en_ff;
  logic dirty_ff;
  logic wrote_ff;
  logic [15:0] restore_cnt_ff;
  logic [15:0] pd_cnt_ff;
  logic save_ff;
  logic restore_ff;
  logic standby_ff;

  // Pins pass two flops; the second stage and a delayed copy of clock, select and supply feed logic
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      sync1_ff <= 4'h0;
      sync2_ff <= 4'h0;
      sck_d_ff <= 1'b0;
      cs_d_ff <= 1'b0;
      pg_d_ff <= 1'b0;
    end else begin
      sync1_ff <= {power_good, link.si, link.cs_n, link.sck};
      sync2_ff <= sync1_ff;
      sck_d_ff <= sync2_ff[0];
      cs_d_ff <= sync2_ff[1];
      pg_d_ff <= sync2_ff[3];
    end
  end

  logic sck_s, cs_n_s, si_s, pg_s;
  logic selected, sck_rise, sck_fall, cs_fall, pg_rise, pg_fall;
  logic restore_busy, busy, ready, byte_done, tx_phase, drop;
  logic [7:0] rx_byte;
  logic [7:0] status_byte;
  logic [AW-1:0] addr_full;

  assign sck_s = sync2_ff[0];
  assign cs_n_s = sync2_ff[1];
  assign si_s = sync2_ff[2];
  assign pg_s = sync2_ff[3];
  assign selected = (state_ff != DS_IDLE);
  // Mode 3 starts high, so no rise is seen until the clock has toggled
  assign sck_rise = selected & sck_s & ~sck_d_ff;
  assign sck_fall = selected & ~sck_s & sck_d_ff;
  // Edge qualified: the delay flop clears at reset, so a line already low gives no edge
  assign cs_fall = cs_d_ff & ~cs_n_s;
  assign pg_rise = pg_s & ~pg_d_ff;
  assign pg_fall = ~pg_s & pg_d_ff;
  assign restore_busy = (restore_cnt_ff != 16'h0000);
  assign busy = nv_busy | restore_busy | (pd_cnt_ff != 16'h0000);
  assign ready = pg_s & ~restore_busy;
  assign drop = cs_n_s | ~pg_s;
  assign byte_done = sck_rise & (bit_cnt_ff == 3'd7);
  assign rx_byte = {rx_sh_ff[6:0], si_s};
  assign addr_full = {addr_ff[AW-2:0], si_s};
  assign tx_phase = (state_ff == DS_DATA) & ((op_ff == spd_pkg::READ_CMD) | (op_ff == spd_pkg::STATUS_READ_CMD));

  always_comb begin
    status_byte = 8'h00;
    status_byte[spd_pkg::BUSY_BIT] = busy;
    status_byte[spd_pkg::WRITE_LATCH_BIT] = wel_ff;
    status_byte[spd_pkg::BLOCK_PROTECT_LOW_BIT] = bp_ff[0];
    status_byte[spd_pkg::BLOCK_PROTECT_HIGH_BIT] = bp_ff[1];
    status_byte[spd_pkg::PIN_PROTECT_ENABLE_BIT] = ppe_ff;
  end

  // Framing state
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state_ff <= DS_IDLE;
    end else if (drop) begin
      state_ff <= DS_IDLE;
    end else if (cs_fall & ready) begin
      state_ff <= DS_OPC;
    end else if (byte_done) begin
      case (state_ff)
        DS_OPC: begin
          case (rx_byte)
            spd_pkg::READ_CMD: state_ff <= busy ? DS_IGNORE : DS_ADDR;
            spd_pkg::WRITE_CMD: state_ff <= (wel_ff & ~busy) ? DS_ADDR : DS_IGNORE;
            spd_pkg::STATUS_READ_CMD: state_ff <= DS_DATA;
            spd_pkg::STATUS_WRITE_CMD: state_ff <= wel_ff ? DS_DATA : DS_IGNORE;
            default: state_ff <= DS_IGNORE;
          endcase
        end
        DS_ADDR: begin
          if (addr_byte_ff == 2'(spd_pkg::ADDR_BYTES - 1)) begin
            state_ff <= DS_DATA;
          end
        end
        DS_DATA: begin
          if (op_ff == spd_pkg::STATUS_WRITE_CMD) begin
            state_ff <= DS_IGNORE;
          end
        end
        default: state_ff <= state_ff;
      endcase
    end
  end

  // Bit and byte counting, opcode capture, mode latch
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      bit_cnt_ff <= 3'd0;
      addr_byte_ff <= 2'd0;
      rx_sh_ff <= 8'h00;
      op_ff <= 8'h00;
      mode3_ff <= 1'b0;
    end else if (cs_fall) begin
      bit_cnt_ff <= 3'd0;
      addr_byte_ff <= 2'd0;
      mode3_ff <= sck_s;
    end else if (sck_rise) begin
      bit_cnt_ff <= bit_cnt_ff + 3'd1;
      rx_sh_ff <= rx_byte;
      if (byte_done && state_ff == DS_OPC) begin
        op_ff <= rx_byte;
      end
      if (byte_done && state_ff == DS_ADDR) begin
        addr_byte_ff <= addr_byte_ff + 2'd1;
      end
    end
  end

  // Address shifting and memory strobes
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      addr_ff <= '0;
      mem_addr_ff <= '0;
      mem_wdata_ff <= 8'h00;
      mem_wr_ff <= 1'b0;
      mem_rd_ff <= 1'b0;
    end else begin
      mem_wr_ff <= 1'b0;
      mem_rd_ff <= 1'b0;
      if (sck_rise && !drop && state_ff == DS_ADDR) begin
        addr_ff <= addr_full;
        if (byte_done && addr_byte_ff == 2'(spd_pkg::ADDR_BYTES - 1) && op_ff == spd_pkg::READ_CMD) begin
          mem_addr_ff <= addr_full;
          mem_rd_ff <= 1'b1;
          addr_ff <= addr_inc(addr_full);
        end
      end else if (byte_done && !drop && state_ff == DS_DATA) begin
        if (op_ff == spd_pkg::READ_CMD) begin
          mem_addr_ff <= addr_ff;
          mem_rd_ff <= 1'b1;
          addr_ff <= addr_inc(addr_ff);
        end else if (op_ff == spd_pkg::WRITE_CMD) begin
          mem_addr_ff <= addr_ff;
          mem_wdata_ff <= rx_byte;
          mem_wr_ff <= 1'b1;
          addr_ff <= addr_inc(addr_ff);
        end
      end
    end
  end

  // Transmit shifter and output driver
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      tx_sh_ff <= 8'h00;
      so_ff <= 1'b0;
      so_oe_n_ff <= 1'b1;
    end else begin
      if (mem_rd_ff) begin
        tx_sh_ff <= mem_rdata;
      end else if (byte_done && (rx_byte == spd_pkg::STATUS_READ_CMD || state_ff == DS_DATA)
                   && (state_ff == DS_OPC || op_ff == spd_pkg::STATUS_READ_CMD)) begin
        tx_sh_ff <= status_byte;
      end else if (sck_fall && tx_phase) begin
        tx_sh_ff <= {tx_sh_ff[6:0], 1'b0};
      end
      if (drop || !tx_phase) begin
        so_oe_n_ff <= 1'b1;
      end else if (sck_fall) begin
        so_ff <= tx_sh_ff[7];
        so_oe_n_ff <= 1'b0;
      end
    end
  end

  // Write latch, protect bits and automatic save enable
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      wel_ff <= 1'b0;
      bp_ff <= 2'b00;
      ppe_ff <= 1'b0;
      autosave_en_ff <= 1'b1;
    end else if (!pg_s) begin
      wel_ff <= 1'b0;
    end else if (byte_done && !drop && state_ff == DS_OPC) begin
      case (rx_byte)
        spd_pkg::SET_WRITE_LATCH_CMD: wel_ff <= 1'b1;
        spd_pkg::CLEAR_WRITE_LATCH_CMD: wel_ff <= 1'b0;
        spd_pkg::AUTO_SAVE_ON_CMD: autosave_en_ff <= autosave_en_ff | wel_ff;
        spd_pkg::AUTO_SAVE_OFF_CMD: autosave_en_ff <= autosave_en_ff & ~wel_ff;
        default: wel_ff <= wel_ff;
      endcase
    end else if (byte_done && !drop && state_ff == DS_DATA && op_ff == spd_pkg::STATUS_WRITE_CMD) begin
      bp_ff <= {rx_byte[spd_pkg::BLOCK_PROTECT_HIGH_BIT], rx_byte[spd_pkg::BLOCK_PROTECT_LOW_BIT]};
      ppe_ff <= rx_byte[spd_pkg::PIN_PROTECT_ENABLE_BIT];
    end
  end

  // Power-up restore window and power-down completion delay
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      restore_cnt_ff <= 16'h0000;
      pd_cnt_ff <= 16'h0000;
    end else begin
      if (pg_rise) begin
        restore_cnt_ff <= 16'(RESTORE_CYC);
      end else if (!pg_s) begin
        restore_cnt_ff <= 16'h0000;
      end else if (restore_busy) begin
        restore_cnt_ff <= restore_cnt_ff - 16'h0001;
      end
      if (pg_fall) begin
        pd_cnt_ff <= wrote_ff ? 16'(WDELAY_CYC) : 16'h0001;
      end else if (pg_rise) begin
        pd_cnt_ff <= 16'h0000;
      end else if (pd_cnt_ff != 16'h0000) begin
        pd_cnt_ff <= pd_cnt_ff - 16'h0001;
      end
    end
  end

  // Nonvolatile requests and dirty tracking; a write in the same cycle as a restore stays marked
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      save_ff <= 1'b0;
      restore_ff <= 1'b0;
      dirty_ff <= 1'b0;
      wrote_ff <= 1'b0;
    end else begin
      save_ff <= 1'b0;
      restore_ff <= 1'b0;
      if (pg_rise) begin
        restore_ff <= 1'b1;
      end else if (byte_done && !drop && state_ff == DS_OPC && wel_ff && !busy) begin
        save_ff <= (rx_byte == spd_pkg::SAVE_CMD);
        restore_ff <= (rx_byte == spd_pkg::RESTORE_CMD);
      end else if (pd_cnt_ff == 16'h0001 && !pg_s && autosave_en_ff && dirty_ff) begin
        save_ff <= 1'b1;
      end
      if (mem_wr_ff) begin
        dirty_ff <= 1'b1;
      end else if (save_ff || restore_ff) begin
        dirty_ff <= 1'b0;
      end
      if (mem_wr_ff) begin
        wrote_ff <= 1'b1;
      end else if (cs_fall) begin
        wrote_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      standby_ff <= 1'b1;
    end else begin
      standby_ff <= ~selected & ~busy;
    end
  end

  assign link.so_out = so_ff;
  assign link.so_oe_n = so_oe_n_ff;
  assign mem_addr = mem_addr_ff;
  assign mem_wdata = mem_wdata_ff;
  assign mem_wr = mem_wr_ff;
  assign mem_rd = mem_rd_ff;
  assign nv_save_req = save_ff;
  assign nv_restore_req = restore_ff;
  assign active = selected;
  assign standby = standby_ff;
  assign spi_mode3 = mode3_ff;
endmodule // spd_device_end

// ### spd_host_end.sv
// Serial link controller with an Avalon-MM register port for software
`timescale 1ns/1ns
module spd_host_end #(
  parameter int HALF_CYC = spd_pkg::HALF_CYC
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic [1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  spd_link_if.host_mp link
);
  typedef enum logic [3:0] {
    HS_IDLE = 4'b0001,
    HS_LOW = 4'b0010,
    HS_HIGH = 4'b0100,
    HS_GAP = 4'b1000
  } spd_hstate_type;

  // Half period of 4 keeps the clock at 3.125 MHz and leaves room for the return path
  initial begin
    if (HALF_CYC < 4 || HALF_CYC > 255 || 1000 / (2 * HALF_CYC * spd_pkg::CLK_NS) > spd_pkg::SCK_MAX_MHZ) begin
      $error("spd_host_end: HALF_CYC out of range");
    end
  end

  spd_hstate_type state_ff;
  logic [7:0] half_ff;
  logic [2:0] bit_ff;
  logic [7:0] tx_ff;
  logic [7:0] rx_ff;
  logic last_ff;
  logic mode3_ff;
  logic cs_n_ff;
  logic sck_ff;
  logic mosi_ff;
  logic so1_ff;
  logic so2_ff;
  logic rd_ack_ff;
  logic [31:0] rdata_ff;
  logic half_end, data_wr, ctrl_wr;

  assign half_end = (half_ff == 8'(HALF_CYC - 1));
  assign data_wr = avs_write & (avs_address == spd_pkg::REG_DATA) & (state_ff == HS_IDLE);
  // Mode may only change while deselected so the idle clock level stays valid
  assign ctrl_wr = avs_write & (avs_address == spd_pkg::REG_CTRL) & cs_n_ff;

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      so1_ff <= 1'b0;
      so2_ff <= 1'b0;
    end else begin
      so1_ff <= link.so;
      so2_ff <= so1_ff;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      mode3_ff <= 1'b0;
    end else if (ctrl_wr) begin
      mode3_ff <= avs_writedata[spd_pkg::CTRL_MODE3_BIT];
    end
  end

  // Bit sequencer: low half then high half per bit, input sampled at end of high half
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state_ff <= HS_IDLE;
      half_ff <= 8'h00;
      bit_ff <= 3'd0;
      tx_ff <= 8'h00;
      rx_ff <= 8'h00;
      last_ff <= 1'b0;
      cs_n_ff <= 1'b1;
      sck_ff <= 1'b0;
      mosi_ff <= 1'b0;
    end else begin
      case (state_ff)
        HS_IDLE: begin
          half_ff <= 8'h00;
          if (cs_n_ff) begin
            sck_ff <= ctrl_wr ? avs_writedata[spd_pkg::CTRL_MODE3_BIT] : mode3_ff;
          end
          if (data_wr) begin
            tx_ff <= avs_writedata[7:0];
            mosi_ff <= avs_writedata[7];
            last_ff <= avs_writedata[spd_pkg::DATA_LAST_BIT];
            cs_n_ff <= 1'b0;
            bit_ff <= 3'd0;
            state_ff <= HS_LOW;
          end
        end
        HS_LOW: begin
          if (sck_ff) begin
            // Mode 3: clock stays high across the select edge so the level can be latched, then drops
            sck_ff <= 1'b0;
          end else begin
            half_ff <= half_end ? 8'h00 : half_ff + 8'h01;
            if (half_end) begin
              sck_ff <= 1'b1;
              state_ff <= HS_HIGH;
            end
          end
        end
        HS_HIGH: begin
          half_ff <= half_end ? 8'h00 : half_ff + 8'h01;
          if (half_end) begin
            rx_ff <= {rx_ff[6:0], so2_ff};
            if (bit_ff == 3'd7) begin
              sck_ff <= mode3_ff;
              if (last_ff) begin
                cs_n_ff <= 1'b1;
                state_ff <= HS_GAP;
              end else begin
                state_ff <= HS_IDLE;
              end
            end else begin
              bit_ff <= bit_ff + 3'd1;
              tx_ff <= {tx_ff[6:0], 1'b0};
              mosi_ff <= tx_ff[6];
              sck_ff <= 1'b0;
              state_ff <= HS_LOW;
            end
          end
        end
        HS_GAP: begin
          half_ff <= half_end ? 8'h00 : half_ff + 8'h01;
          if (half_end) begin
            state_ff <= HS_IDLE;
          end
        end
        default: state_ff <= HS_IDLE;
      endcase
    end
  end

  // Reads answer one cycle after the request; unmapped words read zero
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      rd_ack_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
    end else if (avs_read && !rd_ack_ff) begin
      rd_ack_ff <= 1'b1;
      rdata_ff <= 32'h0000_0000;
      case (avs_address)
        spd_pkg::REG_CTRL: rdata_ff[spd_pkg::CTRL_MODE3_BIT] <= mode3_ff;
        spd_pkg::REG_DATA: rdata_ff[7:0] <= rx_ff;
        spd_pkg::REG_STAT: begin
          rdata_ff[spd_pkg::STAT_BUSY_BIT] <= (state_ff != HS_IDLE);
          rdata_ff[spd_pkg::STAT_SEL_BIT] <= ~cs_n_ff;
        end
        default: rdata_ff <= 32'h0000_0000;
      endcase
    end else begin
      rd_ack_ff <= 1'b0;
    end
  end

  assign avs_waitrequest = (avs_read & ~rd_ack_ff)
                         | (avs_write & (avs_address == spd_pkg::REG_DATA) & (state_ff != HS_IDLE));
  assign avs_readdata = rdata_ff;
  assign link.cs_n = cs_n_ff;
  assign link.sck = sck_ff;
  assign link.si = mosi_ff;
endmodule // spd_host_end

// ### spd_link_sva.sv
// Checker for the serial link between the controller and the memory front end
`timescale 1ns/1ns
module spd_link_sva (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic cs_n,
  input wire logic sck,
  input wire logic si,
  input wire logic so_out,
  input wire logic so_oe_n
);
  logic sck_ff;
  logic [6:0] rise_cnt_ff;
  logic [7:0] op_ff;
  wire rise = sck && !sck_ff && !cs_n;
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (reset);
  always_ff @(posedge sys_clk) begin
    sck_ff <= sck;
  end
  // Clock rises within the current select
  always_ff @(posedge sys_clk) begin
    if (reset || cs_n) begin
      rise_cnt_ff <= 7'h00;
    end else if (rise) begin
      rise_cnt_ff <= rise_cnt_ff + 7'h01;
    end
  end
  always_ff @(posedge sys_clk) begin
    if (rise && rise_cnt_ff < 7'h08) begin
      op_ff <= {op_ff[6:0], si};
    end
  end
  AST_DESEL_QUIET: assert property (cs_n [*6] |-> so_oe_n)
    else $error("so driven while deselected");
  AST_OPCODE_QUIET: assert property (!cs_n && rise_cnt_ff < 7'h08 |-> so_oe_n)
    else $error("so driven in opcode");
  AST_NONREAD_QUIET: assert property (rise_cnt_ff >= 7'h08 && op_ff != 8'h03 && op_ff != 8'h05 |-> so_oe_n)
    else $error("so driven for non-read");
  AST_OUT_ON_FALL: assert property (!so_oe_n && $past(!so_oe_n) && $changed(so_out) |-> !sck)
    else $error("so moved with sck high");
  AST_SEL_CLOCK_STILL: assert property ($fell(cs_n) |-> $stable(sck))
    else $error("sck moved at select");
  AST_HIGH_HALF: assert property ($rose(sck) && !cs_n |-> sck [*4])
    else $error("sck high too short");
  AST_LOW_HALF: assert property ($fell(sck) && !cs_n |-> !sck [*4])
    else $error("sck low too short");
  AST_SI_SETUP: assert property ($rose(sck) && !cs_n |-> $stable(si))
    else $error("si moved at rise");
  AST_WHOLE_BYTES: assert property ($rose(cs_n) |-> rise_cnt_ff[2:0] == 3'h0 && rise_cnt_ff != 7'h00)
    else $error("select ended in a byte");
  cover property ($fell(cs_n) && sck);
  cover property (!so_oe_n);
  cover property (rise_cnt_ff == 7'h28);
endmodule // spd_link_sva

// ### tb.sv
// Bench joining the controller and the memory front end over the serial link
`timescale 1ns/1ns
module tb;
  logic sys_clk, reset, power_good, avs_read, avs_write, avs_waitrequest, mem_wr, mem_rd, so_seen;
  logic nv_save_req, nv_restore_req, active, standby, spi_mode3;
  logic [1:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic [7:0] mem_rdata, mem_wdata, wdat, rx;
  logic [16:0] mem_addr, waddr;
  logic nv_busy;
  localparam int NV_BUSY_CYC = 100;
  int fails = 0, n_checks = 0, saves = 0, rests = 0, s, r, busy_cnt = 0;
  spd_link_if link ();
  spd_host_end u_spd_host_end (.sys_clk, .reset, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_readdata, .avs_waitrequest, .link);
  spd_device_end #(.RESTORE_CYC(8), .WDELAY_CYC(4)) u_spd_device_end (.sys_clk, .reset, .link, .power_good,
    .nv_busy, .mem_rdata, .mem_addr, .mem_wdata, .mem_wr, .mem_rd, .nv_save_req, .nv_restore_req,
    .active, .standby, .spi_mode3);
  spd_link_sva u_spd_link_sva (.sys_clk, .reset, .cs_n(link.cs_n), .sck(link.sck), .si(link.si),
    .so_out(link.so_out), .so_oe_n(link.so_oe_n));
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  // Array stand-in: data is a fixed function of the address, a save keeps it busy a while
  assign mem_rdata = mem_addr[7:0] ^ 8'h5A;
  assign nv_busy = (busy_cnt > 0);
  always @(posedge sys_clk) begin
    if (nv_save_req === 1'b1) begin
      busy_cnt <= NV_BUSY_CYC;
    end else if (busy_cnt > 0) begin
      busy_cnt <= busy_cnt - 1;
    end
    saves <= saves + int'(nv_save_req === 1'b1);
    rests <= rests + int'(nv_restore_req === 1'b1);
    if (mem_wr === 1'b1) begin
      waddr <= mem_addr;
      wdat <= mem_wdata;
    end
    if (link.so_oe_n === 1'b0) begin
      so_seen <= 1'b1;
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t %s: %h not %h", $time, what, got, exp);
    end
  endtask
  task automatic av(input logic wr, input logic [1:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    @(posedge sys_clk);
    while (avs_waitrequest !== 1'b0) @(posedge sys_clk);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge sys_clk);
  endtask
  // One select: bytes go out in turn, the last one ends the select
  task automatic xfer(input logic m3, input logic [7:0] b[$]);
    av(1'b1, spd_pkg::REG_CTRL, {31'h0, m3});
    foreach (b[i]) av(1'b1, spd_pkg::REG_DATA, {23'h0, i == b.size() - 1, b[i]});
    do av(1'b0, spd_pkg::REG_STAT, 32'h0); while (rd[spd_pkg::STAT_BUSY_BIT] !== 1'b0);
    av(1'b0, spd_pkg::REG_DATA, 32'h0);
    rx = rd[7:0];
  endtask
  task automatic t_reset;
    chk({link.cs_n, link.so_oe_n, standby, active}, 4'hE, "reset state");
    reset <= 1'b0;
    repeat (20) @(posedge sys_clk);
    chk(rests, 1, "powerup restore");
    av(1'b1, 2'h3, 32'hFFFF_FFFF);
    av(1'b0, 2'h3, 32'h0);
    chk(rd, 32'h0, "unmapped read");
    $display("t_reset done");
  endtask
  task automatic t_status;
    xfer(1'b0, '{8'h05, 8'h00});
    chk(rx, 8'h00, "status at start");
    xfer(1'b1, '{8'h06});
    xfer(1'b1, '{8'h01, 8'hFF});
    xfer(1'b1, '{8'h05, 8'h00});
    chk(rx, 8'h8E, "status write");
    xfer(1'b0, '{8'h04});
    xfer(1'b0, '{8'h05, 8'h00});
    chk(rx, 8'h8C, "latch clear");
    $display("t_status done");
  endtask
  task automatic t_mem;
    xfer(1'b1, '{8'h06});
    xfer(1'b1, '{8'h02, 8'hFF, 8'hFF, 8'h34, 8'hAB});
    chk(waddr, 17'h1_FF34, "write addr");
    chk(wdat, 8'hAB, "write data");
    chk(spi_mode3, 1'b1, "mode 3");
    xfer(1'b0, '{8'h03, 8'h00, 8'h01, 8'h12, 8'h00});
    chk(rx, 8'h48, "read data");
    chk(spi_mode3, 1'b0, "mode 0");
    so_seen = 1'b0;
    xfer(1'b0, '{8'h1E, 8'h05, 8'h00});
    chk(so_seen, 1'b0, "bad opcode");
    $display("t_mem done");
  endtask
  task automatic t_nv;
    s = saves;
    r = rests;
    xfer(1'b1, '{8'h06});
    xfer(1'b1, '{8'h3C});
    chk(standby, 1'b0, "standby during save");
    xfer(1'b0, '{8'h05, 8'h00});
    chk(rx, 8'h8F, "busy during save");
    chk(standby, 1'b1, "standby after save");
    xfer(1'b0, '{8'h60});
    xfer(1'b1, '{8'h19});
    xfer(1'b0, '{8'h59});
    chk(saves - s, 1, "save cmd");
    chk(rests - r, 1, "restore cmd");
    xfer(1'b0, '{8'h02, 8'h00, 8'h00, 8'h01, 8'h55});
    s = saves;
    power_good <= 1'b0;
    repeat (30) @(posedge sys_clk);
    chk(saves - s, 1, "auto save");
    power_good <= 1'b1;
    repeat (60) @(posedge sys_clk);
    chk(rests - r, 2, "restore at power");
    xfer(1'b0, '{8'h05, 8'h00});
    chk(rx, 8'h8C, "status after power");
    $display("t_nv done");
  endtask
  task automatic end_of_test;
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    #2000000;
    fails++;
    end_of_test;
  end
  initial begin
    reset = 1'b1;
    power_good = 1'b1;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 2'h0;
    avs_writedata = 32'h0;
    so_seen = 1'b0;
    repeat (20) @(posedge sys_clk);
    t_reset;
    t_status;
    t_mem;
    t_nv;
    end_of_test;
  end
endmodule // tb
